// ==== src/xy_add_logic_bit_block_move.v ====
// Execution block: packed XY immediate add, AND family, bit block copy, APB slave
`include "xy_logic_map.vh"

module xy_add_logic_bit_block_move (
   // Clock and reset
   input  wire        clock,
   input  wire        srst,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Interrupt request from the core, asynchronous to this block
   input  wire        irq_in,
   // Trap outcome and completion for the core
   output reg         rewind_pulse,
   output reg         push_pc_pulse,
   output reg         push_flags_pulse,
   output reg         done
);

   localparam S_IDLE  = 3'h0;
   localparam S_EXEC  = 3'h1;
   localparam S_COPY  = 3'h2;
   localparam S_PUSHP = 3'h3;
   localparam S_PUSHF = 3'h4;

   reg  [2:0]  state_q;
   reg  [2:0]  op_q;
   reg         align_q;
   reg         src_sel_q;
   reg         dst_sel_q;
   reg  [31:0] opa_q;
   reg  [31:0] opb_q;
   reg  [31:0] result_q;
   reg  [3:0]  flags_word;
   reg  [31:0] src_bit_pointer;
   reg  [31:0] dst_bit_pointer;
   reg  [31:0] bit_count_reg;
   reg  [31:0] orig_count_q;
   reg  [2:0]  states_left_q;
   reg  [2:0]  states_used_q;
   reg         busy_q;
   reg         irq_meta_q;
   reg         irq_sync_q;

   wire        wr_en = psel & penable & pwrite & ~pready;
   wire        rd_en = psel & penable & ~pwrite & ~pready;
   wire        go = wr_en && (paddr == `REG_CTRL) && pwdata[`CTRL_GO_BIT] && !busy_q;

   // XY add on two independent 16-bit lanes
   wire [15:0] sum_x = opa_q[15:0] + opb_q[15:0];
   wire [15:0] sum_y = opa_q[31:16] + opb_q[31:16];
   wire [31:0] xy_res = {sum_y, sum_x};
   reg  [31:0] logic_res;
   wire [31:0] step = (bit_count_reg < `COPY_STEP) ? bit_count_reg : `COPY_STEP;

   always @* begin
      case (op_q)
         `OP_AND_REG:  logic_res = opa_q & opb_q;
         `OP_MASK_WITH_INVERTED_REG_REG: logic_res = ~opa_q & opb_q;
         `OP_MASK_WITH_INVERTED_REG_IMM: logic_res = ~opa_q & opb_q;
         default:      logic_res = opa_q & opb_q;
      endcase
   end

   // Interrupt line crosses into this clock
   always @(posedge clock) begin
      if (srst) begin
         irq_meta_q <= 1'b0;
         irq_sync_q <= 1'b0;
      end else begin
         irq_meta_q <= irq_in;
         irq_sync_q <= irq_meta_q;
      end
   end

   // Execution state machine
   always @(posedge clock) begin
      if (srst) begin
         state_q          <= S_IDLE;
         op_q             <= `OP_XY_IMM;
         align_q          <= 1'b0;
         src_sel_q        <= 1'b0;
         dst_sel_q        <= 1'b0;
         opa_q            <= `ZERO32;
         opb_q            <= `ZERO32;
         result_q         <= `ZERO32;
         flags_word       <= 4'h0;
         src_bit_pointer  <= `ZERO32;
         dst_bit_pointer  <= `ZERO32;
         bit_count_reg    <= `ZERO32;
         orig_count_q     <= `ZERO32;
         states_left_q    <= 3'h0;
         states_used_q    <= 3'h0;
         busy_q           <= 1'b0;
         done             <= 1'b0;
         rewind_pulse     <= 1'b0;
         push_pc_pulse    <= 1'b0;
         push_flags_pulse <= 1'b0;
      end else begin
         done             <= 1'b0;
         rewind_pulse     <= 1'b0;
         push_pc_pulse    <= 1'b0;
         push_flags_pulse <= 1'b0;
         if (wr_en && !busy_q) begin
            case (paddr)
               `REG_OPERAND_A: opa_q <= pwdata;
               `REG_OPERAND_B: opb_q <= pwdata;
               `REG_FLAGS:     flags_word <= pwdata[3:0];
               `REG_SRC_PTR:   src_bit_pointer <= pwdata;
               `REG_DST_PTR:   dst_bit_pointer <= pwdata;
               `REG_COUNT:     bit_count_reg <= pwdata;
               default: ;
            endcase
         end
         case (state_q)
            S_IDLE: begin
               if (go) begin
                  op_q      <= pwdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
                  align_q   <= pwdata[`CTRL_ALIGN_BIT];
                  src_sel_q <= pwdata[`CTRL_SRC_SEL];
                  dst_sel_q <= pwdata[`CTRL_DST_SEL];
                  busy_q    <= 1'b1;
                  if (pwdata[`CTRL_OP_MSB:`CTRL_OP_LSB] == `OP_BLOCK_COPY) begin
                     orig_count_q <= bit_count_reg;
                     state_q      <= S_COPY;
                  end else begin
                     // Register forms take one state, immediate forms two or three
                     case (pwdata[`CTRL_OP_MSB:`CTRL_OP_LSB])
                        `OP_AND_REG, `OP_MASK_WITH_INVERTED_REG_REG:
                           states_left_q <= `STATES_REG;
                        default:
                           states_left_q <= pwdata[`CTRL_ALIGN_BIT] ?
                              `STATES_IMM_AL : `STATES_IMM_UNAL;
                     endcase
                     states_used_q <= 3'h0;
                     state_q       <= S_EXEC;
                  end
               end
            end
            S_EXEC: begin
               states_used_q <= states_used_q + 3'h1;
               if (states_left_q == 3'h1) begin
                  if (op_q == `OP_XY_IMM) begin
                     result_q             <= xy_res;
                     opb_q                <= xy_res;
                     flags_word[`FLAG_N]  <= (sum_x == `ZERO16);
                     flags_word[`FLAG_Z]  <= (sum_y == `ZERO16);
                     flags_word[`FLAG_C]  <= sum_y[15];
                     flags_word[`FLAG_V]  <= sum_x[15];
                  end else begin
                     result_q            <= logic_res;
                     opb_q               <= logic_res;
                     flags_word[`FLAG_Z] <= (logic_res == `ZERO32);
                  end
                  busy_q  <= 1'b0;
                  done    <= 1'b1;
                  state_q <= S_IDLE;
               end
               states_left_q <= states_left_q - 3'h1;
            end
            S_COPY: begin
               // Interrupt check between steps; restart reuses the registers
               if (irq_sync_q && bit_count_reg != `ZERO32) begin
                  rewind_pulse <= 1'b1;
                  state_q      <= S_PUSHP;
               end else if (bit_count_reg == `ZERO32) begin
                  // Final pointer fix-up lands with done
                  src_bit_pointer <= (src_sel_q && dst_sel_q) ? src_bit_pointer
                                     : src_bit_pointer + orig_count_q;
                  if (!dst_sel_q)
                     dst_bit_pointer <= dst_bit_pointer + orig_count_q;
                  busy_q  <= 1'b0;
                  done    <= 1'b1;
                  state_q <= S_IDLE;
               end else begin
                  // Word-sized steps through one contiguous bit run
                  bit_count_reg <= bit_count_reg - step;
                  if (dst_sel_q)
                     dst_bit_pointer <= dst_bit_pointer + step;
                  if (src_sel_q && dst_sel_q)
                     src_bit_pointer <= src_bit_pointer + step;
               end
            end
            S_PUSHP: begin
               push_pc_pulse <= 1'b1;
               state_q       <= S_PUSHF;
            end
            S_PUSHF: begin
               push_flags_pulse <= 1'b1;
               busy_q           <= 1'b0;
               state_q          <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // APB answer: one wait state, reads see live state
   always @(posedge clock) begin
      if (srst) begin
         prdata  <= `ZERO32;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= 1'b0;
         if (rd_en) begin
            case (paddr)
               `REG_CTRL:      prdata <= {`CTRL_PAD, dst_sel_q, src_sel_q, align_q,
                                          op_q, busy_q};
               `REG_OPERAND_A: prdata <= opa_q;
               `REG_OPERAND_B: prdata <= opb_q;
               `REG_RESULT:    prdata <= result_q;
               `REG_FLAGS:     prdata <= {28'h0000000, flags_word};
               `REG_SRC_PTR:   prdata <= src_bit_pointer;
               `REG_DST_PTR:   prdata <= dst_bit_pointer;
               `REG_COUNT:     prdata <= bit_count_reg;
               `REG_STATUS:    prdata <= {31'h00000000, busy_q};
               `REG_STATES:    prdata <= {29'h00000000, states_used_q};
               default: begin
                  prdata  <= `ZERO32;
                  pslverr <= 1'b1;
               end
            endcase
         end else if (wr_en) begin
            // Writes outside the map are flagged, not stored
            case (paddr)
               `REG_CTRL, `REG_OPERAND_A, `REG_OPERAND_B, `REG_FLAGS,
               `REG_SRC_PTR, `REG_DST_PTR, `REG_COUNT: pslverr <= 1'b0;
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

endmodule

// ==== src/xy_logic_map.vh ====
// Constants for the XY add, mask and bit block copy execution block
`ifndef XY_LOGIC_MAP_VH
`define XY_LOGIC_MAP_VH
// APB register offsets (byte addresses)
`define REG_CTRL        12'h000
`define REG_OPERAND_A   12'h004
`define REG_OPERAND_B   12'h008
`define REG_RESULT      12'h00C
`define REG_FLAGS       12'h010
`define REG_SRC_PTR     12'h014
`define REG_DST_PTR     12'h018
`define REG_COUNT       12'h01C
`define REG_STATUS      12'h020
`define REG_STATES      12'h024
// Control register fields
`define CTRL_GO_BIT     0
`define CTRL_OP_LSB     1
`define CTRL_OP_MSB     3
`define CTRL_ALIGN_BIT  4
`define CTRL_SRC_SEL    5
`define CTRL_DST_SEL    6
`define CTRL_IRQ_BIT    7
// Operation codes
`define OP_XY_IMM       3'h0
`define OP_AND_REG      3'h1
`define OP_MASK_WITH_INVERTED_REG_REG     3'h2
`define OP_MASK_WITH_INVERTED_REG_IMM     3'h3
`define OP_BLOCK_COPY   3'h4
// Flag word bit positions: N C Z V
`define FLAG_N          3
`define FLAG_C          2
`define FLAG_Z          1
`define FLAG_V          0
// Machine state counts
`define STATES_REG      3'h1
`define STATES_IMM_AL   3'h2
`define STATES_IMM_UNAL 3'h3
// Bits moved per copy step at most
`define COPY_STEP       32'h00000020
`define ZERO32          32'h00000000
`define ZERO16          16'h0000
// Upper control read-back bits above the select fields
`define CTRL_PAD        25'h0000000
`endif

// ==== verification/xy_add_logic_bit_block_move_properties.sv ====
// Port checker for the XY add, mask and bit copy block
module xy_blk_chk (
   // Clock and reset
   input logic clock,
   input logic srst,
   // Bus handshake
   input logic psel,
   input logic penable,
   input logic pready,
   input logic pslverr,
   // Completion and trap
   input logic done,
   input logic rewind_pulse,
   input logic push_pc_pulse,
   input logic push_flags_pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   AST_RDY_ONE:
      assert property (pready |=> !pready) else $error("pready held too long");
   AST_RDY_LAT:
      assert property (psel && $rose(penable) |=> pready) else $error("pready late");
   AST_RDY_CAUSE:
      assert property (pready |-> $past(psel && penable)) else $error("pready unasked");
   AST_ERR_RDY:
      assert property (pslverr |-> pready) else $error("pslverr without pready");
   AST_DONE_ONE:
      assert property (done |=> !done) else $error("done held too long");
   AST_REWIND_PC:
      assert property (rewind_pulse |=> push_pc_pulse && !rewind_pulse) else $error("no pc push");
   AST_PC_FLAGS:
      assert property (push_pc_pulse |=> push_flags_pulse) else $error("no flags push");
   AST_FLAGS_ORDER:
      assert property (push_flags_pulse |-> $past(push_pc_pulse)) else $error("flags push early");
   cover property (done);
   cover property (rewind_pulse);
   cover property (pslverr);
endmodule

// ==== verification/tb_xy_add_logic_bit_block_move.sv ====
// Self-checking bench for the XY add, mask and bit copy block
`include "xy_logic_map.vh"
module tb_xy_add_logic_bit_block_move;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock, srst, psel, penable, pwrite, irq_in, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, a, b, r, f0;
   logic        pready, pslverr, rewind_pulse, push_pc_pulse, push_flags_pulse, done;
   logic [2:0]  op;
   logic        al;
   int          n_mismatch, n_checks, cnt, lat, got, seed, i, n;

   xy_add_logic_bit_block_move i_xy_add_logic_bit_block_move (.clock, .srst, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_in,
      .rewind_pulse, .push_pc_pulse, .push_flags_pulse, .done);

   // Cycles counted from the edge where a control write is taken
   always @(posedge clock) begin
      if (done) begin
         lat = cnt;
         got = 1;
      end
      if (rewind_pulse)
         got = 2;
      cnt = (psel && penable && pwrite && paddr == `REG_CTRL && !pready) ? 0 : cnt + 1;
   end

   task automatic results;
      $display("Mismatches %0d, checks %0d", n_mismatch, n_checks);
      if (n_mismatch == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic fail;
      n_mismatch++;
      $display("Error %0t: timeout", $time);
      results;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %0t: got %h exp %h", $time, g, e);
      end
   endtask

   // One idle edge first, so release and a new setup never share a time step
   task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clock);
      psel <= 1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'h1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      if (k >= 20)
         fail;
   endtask

   task automatic run(input logic [31:0] ctl, input int want);
      int k;
      k = 0;
      got = 0;
      bus(1, `REG_CTRL, ctl);
      irq_in <= (want == 2);
      while (got != want && k < 300) begin
         @(posedge clock);
         k++;
      end
      if (k >= 300)
         fail;
   endtask

   function automatic logic [31:0] alu(input logic [2:0] o, input logic [31:0] s, d);
      logic [15:0] x, y;
      x = s[15:0] + d[15:0];
      y = s[31:16] + d[31:16];
      if (o == 0)
         return {y, x};
      return (o == 1) ? s & d : ~s & d;
   endfunction

   function automatic logic [31:0] flg(input logic [2:0] o, input logic [31:0] r, f);
      if (o == 0)
         return {28'h0, r[15:0] == 0, r[31], r[31:16] == 0, r[15]};
      return {28'h0, f[3:2], r == 0, f[0]};
   endfunction

   initial begin
      clock = 0;
      forever #2 clock = ~clock;
   end

   initial begin
      {psel, penable, pwrite, irq_in, paddr, pwdata} = '0;
      srst = 1;
      seed = 32'h3A70284F;
      {n_mismatch, n_checks, cnt, got, lat} = '0;
      repeat (5) @(posedge clock);
      srst <= 0;
      bus(0, 12'h100, 0);
      chk(err, 1);
      chk(rd, 0);
      // First rounds use equal operands: both inverted-mask forms clear the register
      for (i = 0; i < 24; i++) begin
         op = i % 4;
         al = $random(seed);
         a = $random(seed);
         b = (i < 4) ? a : $random(seed);
         f0 = $random(seed) & 32'h0000000F;
         bus(1, `REG_FLAGS, f0);
         bus(1, `REG_OPERAND_A, a);
         bus(1, `REG_OPERAND_B, b);
         run({27'h0, al, op, 1'h1}, 1);
         r = alu(op, a, b);
         n = (op == 1 || op == 2) ? 1 : 3 - al;
         chk(lat, n);
         bus(0, `REG_RESULT, 0);
         chk(rd, r);
         bus(0, `REG_OPERAND_B, 0);
         chk(rd, r);
         bus(0, `REG_FLAGS, 0);
         chk(rd, flg(op, r, f0));
         bus(0, `REG_STATES, 0);
         chk(rd, n);
      end
      for (i = 0; i < 4; i++) begin
         a = $random(seed) & (i[0] ? 32'hFFFFFFFF : 32'hFFFFFFE0);
         b = $random(seed) & (i[1] ? 32'hFFFFFFFF : 32'hFFFFFFE0);
         n = (i == 0) ? 1 : (i == 1) ? 32 : ($random(seed) & 255) + 33;
         bus(1, `REG_SRC_PTR, a);
         bus(1, `REG_DST_PTR, b);
         bus(1, `REG_COUNT, n);
         run({25'h0, i[1:0], 4'h9}, 1);
         chk(lat, (n + 31) / 32 + 1);
         bus(0, `REG_SRC_PTR, 0);
         chk(rd, a + n);
         bus(0, `REG_DST_PTR, 0);
         chk(rd, b + n);
         bus(0, `REG_COUNT, 0);
         chk(rd, 0);
      end
      bus(1, `REG_COUNT, 1000);
      run(32'h00000069, 2);
      irq_in <= 0;
      repeat (3) @(posedge clock);
      bus(0, `REG_STATUS, 0);
      chk(rd & 1, 0);
      // Trap routine reloads the count with 64 before the copy restarts
      bus(1, `REG_COUNT, 64);
      run(32'h00000069, 1);
      chk(lat, 3);
      results;
   end
endmodule

bind xy_add_logic_bit_block_move xy_blk_chk i_xy_blk_chk (.clock, .srst, .psel, .penable,
   .pready, .pslverr, .done, .rewind_pulse, .push_pc_pulse, .push_flags_pulse);
